// *** spise_pkg.sv ***
// spise_pkg: constants, state encoding and crc helper for the spi status block
// assumes a single core clock of 125 MHz and 8-bit msb-first frames
package spise_pkg;
    localparam int unsigned CORE_HZ    = 125_000_000;
    localparam int unsigned SCK_MAX_HZ = 16_000_000;
    // least half period of the master sck, rounded up to whole core cycles
    localparam int unsigned HALF_CYC   = (CORE_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
    localparam int unsigned DIV_W      = 3;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
    localparam int unsigned FRAME_W    = 8;
    localparam int unsigned CNT_W      = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
    localparam int unsigned MSB        = FRAME_W - 1;
    localparam logic [FRAME_W-1:0] WORD_ZERO = 8'h00;
    localparam logic [FRAME_W-1:0] CRC_POLY  = 8'h07;
    localparam logic [FRAME_W-1:0] CRC_INIT  = 8'h00;

    typedef enum logic [1:0] {
        SPISE_IDLE   = 2'b00,
        SPISE_MASTER = 2'b01,
        SPISE_SLAVE  = 2'b10
    } spise_state_type;

    // one crc-8 step over a whole received word, msb first
    function automatic logic [FRAME_W-1:0] spise_crc8(input logic [FRAME_W-1:0] crc,
                                                      input logic [FRAME_W-1:0] data);
        logic [FRAME_W-1:0] c;
        c = crc ^ data;
        for (int i = 0; i < FRAME_W; i++) begin
            c = c[MSB] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : spise_crc8
endpackage : spise_pkg

// *** spise_pin_if.sv ***
// spise_pin_if: synchronised pin levels and sck edge events
// assumes one core clock domain on both sides
`timescale 1ns/1ps
interface spise_pin_if;
    logic sck;
    logic sck_rise;
    logic sck_fall;
    logic nss;
    logic mosi;
    logic miso;
    modport sync (output sck, sck_rise, sck_fall, nss, mosi, miso);
    modport core (input  sck, sck_rise, sck_fall, nss, mosi, miso);
endinterface : spise_pin_if

// *** spise_sync.sv ***
// spise_sync: three-stage synchronisers for the serial pins
// assumes pins are asynchronous to core_clk; a change counts once stages 2 and 3 agree
`timescale 1ns/1ps
module spise_sync (
    input  wire logic   core_clk,
    input  wire logic   rst,
    input  wire logic   clk_en,
    input  wire logic   sck_in,
    input  wire logic   nss_in,
    input  wire logic   mosi_in,
    input  wire logic   miso_in,
    spise_pin_if.sync   pins
);
    import spise_pkg::*;

    localparam int unsigned     N        = 4;
    // pin order miso, mosi, nss, sck; only nss idles high
    localparam logic [N-1:0]    PIN_IDLE = 4'h2;
    logic [N-1:0] s1, s2, s3, lvl;
    logic [N-1:0] next_s1, next_s2, next_s3, next_lvl;

    // stage 1 is read only by stage 2; the filter looks at stages 2 and 3
    always_comb begin
        next_s1   = {miso_in, mosi_in, nss_in, sck_in};
        next_s2   = s1;
        next_s3   = s2;
        next_lvl  = lvl;
        for (int i = 0; i < N; i++) begin
            if (s2[i] == s3[i]) begin
                next_lvl[i] = s3[i];
            end
        end
    end

    // nss idles high, the rest low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1   <= PIN_IDLE;
            s2   <= PIN_IDLE;
            s3   <= PIN_IDLE;
            lvl  <= PIN_IDLE;
        end else if (clk_en) begin
            s1   <= next_s1;
            s2   <= next_s2;
            s3   <= next_s3;
            lvl  <= next_lvl;
        end
    end

    // filtered levels leave at once: a fourth flop would eat the master's whole half period
    assign pins.sck      = next_lvl[0];
    assign pins.nss      = next_lvl[1];
    assign pins.mosi     = next_lvl[2];
    assign pins.miso     = next_lvl[3];
    assign pins.sck_rise = !lvl[0] && next_lvl[0] && clk_en;
    assign pins.sck_fall = lvl[0] && !next_lvl[0] && clk_en;
endmodule : spise_sync

// *** spise_core.sv ***
// spise_core: spi master/slave with transfer-active, buffer and checksum status
// assumes mode 0 framing, 8-bit msb first; pins pass through spise_sync
// Functional notes
// - slave clears transfer-active at every frame end
// - receive-full rises only after last bit stored
// - disabling mid-frame finishes frame, then active drops
// - last bit captured before copy or compare
// - late capture shows stale bit or checksum error
// - capture path matters for receiving master only
// - master sck held at or below 16 MHz
`timescale 1ns/1ps
module spise_core (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    clk_en,
    input  wire logic                    serial_port_enable,
    input  wire logic                    master_mode,
    input  wire logic                    rx_only,
    input  wire logic                    bidir_mode,
    input  wire logic                    bidir_out,
    input  wire logic                    crc_next,
    input  wire logic                    crc_err_clear,
    input  wire logic                    tx_write,
    input  wire logic [spise_pkg::MSB:0] tx_data,
    input  wire logic                    rx_read,
    output logic      [spise_pkg::MSB:0] rx_data,
    output logic                         transmit_buffer_empty_flag,
    output logic                         receive_buffer_full_flag,
    output logic                         transfer_active_flag,
    output logic                         checksum_error_flag,
    input  wire logic                    sck_in,
    output logic                         sck_out,
    output logic                         sck_oe,
    input  wire logic                    nss_in,
    input  wire logic                    mosi_in,
    output logic                         mosi_out,
    output logic                         mosi_oe,
    input  wire logic                    miso_in,
    output logic                         miso_out,
    output logic                         miso_oe
);
    import spise_pkg::*;

    spise_pin_if pins ();

    spise_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .sck_in   (sck_in),
        .nss_in   (nss_in),
        .mosi_in  (mosi_in),
        .miso_in  (miso_in),
        .pins     (pins)
    );

    spise_state_type    state, next_state;
    logic [MSB:0]       shift, next_shift;
    logic [MSB:0]       tx_buf, next_tx_buf;
    logic [MSB:0]       next_rx_data;
    logic [MSB:0]       crc, next_crc;
    logic [CNT_W-1:0]   cnt, next_cnt;
    logic [DIV_W-1:0]   div, next_div;
    logic               next_tbe, next_rxf, next_busy, next_crc_err;
    logic               next_sck, next_sck_oe, next_mosi, next_mosi_oe;
    logic               next_miso, next_miso_oe;
    logic               check_pend, next_check_pend;
    // decoded direction
    logic               receiving, driving, sample, word_done, frame_end;
    logic [MSB:0]       word;

    // a receiving party unless bidir is set to drive
    assign receiving = !(bidir_mode && bidir_out);
    assign driving   = bidir_mode ? bidir_out : !rx_only;

    always_comb begin
        next_state      = state;
        next_shift      = shift;
        next_tx_buf     = tx_buf;
        next_rx_data    = rx_data;
        next_crc        = crc;
        next_cnt        = cnt;
        next_div        = div;
        next_tbe        = transmit_buffer_empty_flag;
        next_rxf        = receive_buffer_full_flag;
        next_crc_err    = checksum_error_flag;
        next_check_pend = check_pend;
        next_sck        = sck_out;
        word_done       = 1'b0;
        frame_end       = 1'b0;
        // master samples its partner pin; bidir shares the one data line
        if (state == SPISE_MASTER) begin
            sample = bidir_mode ? pins.mosi : pins.miso;
        end else begin
            sample = bidir_mode ? pins.miso : pins.mosi;
        end
        // last bit joins the word in the same cycle it is copied and compared
        word = {shift[MSB-1:0], sample};

        // clears first, so a same-cycle hardware set wins
        if (rx_read) begin
            next_rxf = 1'b0;
        end
        if (crc_err_clear) begin
            next_crc_err = 1'b0;
        end
        if (crc_next) begin
            next_check_pend = 1'b1;
        end

        case (state)
            SPISE_IDLE: begin
                next_sck = 1'b0;
                next_cnt = CNT_ZERO;
                next_div = DIV_LAST;
                if (serial_port_enable && master_mode && (!transmit_buffer_empty_flag
                                                          || !driving)) begin
                    next_state = SPISE_MASTER;
                    next_shift = driving ? tx_buf : WORD_ZERO;
                    next_tbe   = 1'b1;
                end else if (serial_port_enable && !master_mode && !pins.nss) begin
                    next_state = SPISE_SLAVE;
                    next_shift = transmit_buffer_empty_flag ? WORD_ZERO : tx_buf;
                    next_tbe   = 1'b1;
                end
            end
            SPISE_MASTER: begin
                // half period of HALF_CYC cycles keeps sck at or under the limit
                if (div != DIV_ZERO) begin
                    next_div = div - 1'b1;
                end else begin
                    next_div = DIV_LAST;
                    next_sck = !sck_out;
                    if (!sck_out) begin
                        next_cnt   = cnt + CNT_ONE;
                        next_shift = word;
                        word_done  = (cnt == CNT_FULL - CNT_ONE) && receiving;
                    end else if (cnt == CNT_FULL) begin
                        frame_end = 1'b1;
                    end
                end
            end
            SPISE_SLAVE: begin
                if (pins.sck_rise) begin
                    next_cnt   = cnt + CNT_ONE;
                    next_shift = word;
                    word_done  = (cnt == CNT_FULL - CNT_ONE) && receiving;
                end else if (pins.sck_fall && cnt == CNT_FULL) begin
                    frame_end = 1'b1;
                end else if (pins.nss) begin
                    next_state = SPISE_IDLE; // deselect aborts a partial frame
                end
            end
            default: begin
                next_state = SPISE_IDLE;
            end
        endcase

        // a frame that ends either reloads or returns to idle
        if (frame_end) begin
            next_cnt = CNT_ZERO;
            if (serial_port_enable && (state == SPISE_MASTER || !pins.nss)
                && (!transmit_buffer_empty_flag || !driving)) begin
                next_shift = driving ? tx_buf : WORD_ZERO;
                next_tbe   = 1'b1;
            end else begin
                next_state = SPISE_IDLE; // disable mid-frame lands here
            end
        end

        // received word stored and the full flag set together, half an sck period before the frame end
        if (word_done) begin
            next_rx_data = word;
            next_rxf     = 1'b1;
            if (check_pend) begin
                next_check_pend = 1'b0;
                next_crc        = CRC_INIT;
                next_crc_err    = (word != crc) || next_crc_err;
            end else begin
                next_crc = spise_crc8(crc, word);
            end
        end

        // software write empties nothing until the shifter takes it
        if (tx_write) begin
            next_tx_buf = tx_data;
            next_tbe    = 1'b0;
        end
    end

    // busy follows the registered state; slave busy ends on the synced frame edge
    always_comb begin
        next_busy = (next_state == SPISE_MASTER)
                    || (next_state == SPISE_SLAVE && next_cnt != CNT_ZERO);
        next_sck_oe  = (next_state == SPISE_MASTER) || (serial_port_enable && master_mode);
        // mode 0: hold mosi over the high phase so the partner never races its rising edge
        if (state == SPISE_MASTER && next_sck) begin
            next_mosi = mosi_out;
        end else begin
            next_mosi = next_shift[MSB];
        end
        next_mosi_oe = (next_state == SPISE_MASTER) && driving;
        next_miso    = next_shift[MSB];
        next_miso_oe = (next_state == SPISE_SLAVE) && !pins.nss && driving;
    end

    // every output is a flop; clock enable low freezes all of it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state                      <= SPISE_IDLE;
            shift                      <= WORD_ZERO;
            tx_buf                     <= WORD_ZERO;
            rx_data                    <= WORD_ZERO;
            crc                        <= CRC_INIT;
            cnt                        <= CNT_ZERO;
            div                        <= DIV_ZERO;
            check_pend                 <= 1'b0;
            transmit_buffer_empty_flag <= 1'b1;
            receive_buffer_full_flag   <= 1'b0;
            transfer_active_flag       <= 1'b0;
            checksum_error_flag        <= 1'b0;
            sck_out                    <= 1'b0;
            sck_oe                     <= 1'b0;
            mosi_out                   <= 1'b0;
            mosi_oe                    <= 1'b0;
            miso_out                   <= 1'b0;
            miso_oe                    <= 1'b0;
        end else if (clk_en) begin
            state                      <= next_state;
            shift                      <= next_shift;
            tx_buf                     <= next_tx_buf;
            rx_data                    <= next_rx_data;
            crc                        <= next_crc;
            cnt                        <= next_cnt;
            div                        <= next_div;
            check_pend                 <= next_check_pend;
            transmit_buffer_empty_flag <= next_tbe;
            receive_buffer_full_flag   <= next_rxf;
            transfer_active_flag       <= next_busy;
            checksum_error_flag        <= next_crc_err;
            sck_out                    <= next_sck;
            sck_oe                     <= next_sck_oe;
            mosi_out                   <= next_mosi;
            mosi_oe                    <= next_mosi_oe;
            miso_out                   <= next_miso;
            miso_oe                    <= next_miso_oe;
        end
    end
endmodule : spise_core

// *** spise_checker.sv ***
// spise_checker: port-level assertions bound onto spise_core
// assumes one core clock domain with synchronous active-high reset
`timescale 1ns/1ps
module spise_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic serial_port_enable,
    input wire logic master_mode,
    input wire logic nss_in,
    input wire logic tx_write,
    input wire logic crc_err_clear,
    input wire logic transmit_buffer_empty_flag,
    input wire logic receive_buffer_full_flag,
    input wire logic transfer_active_flag,
    input wire logic checksum_error_flag,
    input wire logic sck_out,
    input wire logic sck_oe
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);

    // status after reset and around buffer loads
    reset_flags_a: assert property ($fell(rst) |-> transmit_buffer_empty_flag
        && !receive_buffer_full_flag && !transfer_active_flag && !checksum_error_flag)
        else $error("status flags wrong after reset");
    tbe_load_a: assert property (tx_write && clk_en |=> !transmit_buffer_empty_flag)
        else $error("empty flag stayed high after a load");
    rbf_end_a: assert property ($rose(receive_buffer_full_flag) |->
        $past(transfer_active_flag)) else $error("full flag rose outside a frame");
    // slave frames must close once select has been high a while
    slave_idle_a: assert property (!master_mode && nss_in [*6] |->
        !transfer_active_flag) else $error("active flag stuck after slave frame");
    stop_frame_a: assert property ($fell(serial_port_enable) |->
        ##[0:80] !transfer_active_flag) else $error("active flag stuck after disable");
    // each sck phase lasts four core cycles, keeping the link under its ceiling
    sck_high_a: assert property ($rose(sck_out) |-> sck_out [*4])
        else $error("sck high phase too short");
    sck_low_a: assert property ($fell(sck_out) |-> !sck_out [*4])
        else $error("sck low phase too short");
    oe_master_a: assert property (serial_port_enable && master_mode |->
        ##[1:2] sck_oe) else $error("master not driving sck");
    // checksum error is sticky until cleared
    err_hold_a: assert property (checksum_error_flag && !crc_err_clear |=>
        checksum_error_flag) else $error("checksum error dropped by itself");
    err_clear_a: assert property (crc_err_clear && clk_en && !transfer_active_flag |=>
        !checksum_error_flag) else $error("checksum error not cleared");
endmodule : spise_checker

bind spise_core spise_checker u_chk (.*);

// *** spise_peer.sv ***
// spise_peer: behavioural spi partner, slave when the core masters, master otherwise
// assumes mode 0, 8-bit msb-first frames and pin levels resolved by the bench
`timescale 1ns/1ps
module spise_peer (
    input  wire logic master_mode,
    input  wire logic sck_in,
    input  wire logic mosi_in,
    output logic      p_sck,
    output logic      p_nss,
    output logic      p_mosi,
    output logic      p_miso
);
    logic [7:0] reply;
    logic [7:0] got;

    initial begin
        {p_sck, p_mosi, p_miso, reply, got} = '0;
        p_nss = 1'h1;
    end

    // slave side: next bit after each fall; a spent word keeps toggling, never holds
    always @(negedge sck_in) begin
        if (master_mode) begin
            reply = {reply[6:0], ~reply[0]};
            p_miso = reply[7];
        end
    end

    // slave side: sample the core's data line on rising edges
    always @(posedge sck_in) begin
        if (master_mode) got = {got[6:0], mosi_in};
    end

    // msb must be on the line before the first rising edge
    task automatic load(input logic [7:0] v);
        reply = v;
        p_miso = v[7];
    endtask : load

    // master side: 64 ns sck, stands still outside the frame
    task automatic xfer(input logic [7:0] v);
        #3 p_nss = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            p_mosi = v[i];
            #32 p_sck = 1'h1;
            #32 p_sck = 1'h0;
        end
        #32 p_nss = 1'h1;
        p_mosi = ~p_mosi;
    endtask : xfer
endmodule : spise_peer

// *** tb_top.sv ***
// tb_top: self-checking bench for spise_core against the spise_peer model
// assumes spise_pkg, spise_peer and spise_checker are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_top;
    import spise_pkg::*;
    logic         core_clk = 1'h0;
    logic         rst = 1'h1;
    logic         clk_en = 1'h1;
    logic         serial_port_enable = 1'h0;
    logic         master_mode = 1'h1;
    logic         rx_only = 1'h0;
    logic         bidir_mode = 1'h0;
    logic         bidir_out = 1'h0;
    logic         crc_next = 1'h0;
    logic         crc_err_clear = 1'h0;
    logic         tx_write = 1'h0;
    logic [MSB:0] tx_data = WORD_ZERO;
    logic         rx_read = 1'h0;
    logic [MSB:0] rx_data, d, w;
    logic transmit_buffer_empty_flag, receive_buffer_full_flag, transfer_active_flag;
    logic checksum_error_flag, sck_in, sck_out, sck_oe, nss_in, mosi_in, mosi_out;
    logic mosi_oe, miso_in, miso_out, miso_oe, p_sck, p_nss, p_mosi, p_miso;
    logic [MSB:0] exp_q[$];
    int failures = 0;
    int checks = 0;

    // pin levels: whoever enables its driver owns the wire
    assign sck_in = sck_oe ? sck_out : p_sck;
    assign mosi_in = mosi_oe ? mosi_out : p_mosi;
    assign miso_in = miso_oe ? miso_out : p_miso;
    assign nss_in = p_nss;

    spise_core u_dut (.*);
    spise_peer u_peer (.*);

    always #4 core_clk = ~core_clk;

    // every received word is read at once and matched to the oldest note
    always @(posedge core_clk) begin
        rx_read <= (receive_buffer_full_flag === 1'h1) && !rx_read;
        if (receive_buffer_full_flag === 1'h1 && !rx_read) begin
            `CHK(exp_q.size() > 0, 1'h1)
            w = exp_q.pop_front();
            `CHK(rx_data, w)
        end
    end

    task automatic stop_test;
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // bounded poll; sel 0 watches the empty flag, 1 the active flag, 2 a drained queue
    task automatic wait_on(input int sel, input logic v);
        for (int i = 0; i < 300; i++) begin
            @(posedge core_clk);
            if (((sel == 2) ? (exp_q.size() == 0)
                 : (sel ? transfer_active_flag : transmit_buffer_empty_flag)) === v) return;
        end
        failures++;
        stop_test();
    endtask : wait_on

    task automatic send(input logic [MSB:0] v, input logic c);
        @(posedge core_clk);
        tx_write <= 1'h1;
        tx_data <= v;
        crc_next <= c;
        @(posedge core_clk);
        tx_write <= 1'h0;
        crc_next <= 1'h0;
    endtask : send

    // one full-duplex master frame: peer answers s while the core sends v
    task automatic master_frame(input logic [MSB:0] v, input logic [MSB:0] s, input logic c);
        u_peer.load(s);
        exp_q.push_back(s);
        send(v, c);
        wait_on(0, 1'h1);
        wait_on(1, 1'h1);
        wait_on(1, 1'h0);
        `CHK(u_peer.got, v)
    endtask : master_frame

    initial begin
        void'($urandom(32'hE46D6642));
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        @(posedge core_clk);
        `CHK(transmit_buffer_empty_flag, 1'h1)
        `CHK(transfer_active_flag, 1'h0)
        serial_port_enable <= 1'h1;
        // matching checksum must not flag, a wrong one must
        master_frame(8'($urandom), WORD_ZERO, 1'h1);
        `CHK(checksum_error_flag, 1'h0)
        master_frame(8'($urandom), 8'($urandom) | 8'h01, 1'h1);
        `CHK(checksum_error_flag, 1'h1)
        @(posedge core_clk);
        crc_err_clear <= 1'h1;
        @(posedge core_clk);
        crc_err_clear <= 1'h0;
        @(posedge core_clk);
        @(posedge core_clk);
        `CHK(checksum_error_flag, 1'h0)
        for (int k = 0; k < 4; k++) master_frame(8'($urandom), 8'($urandom), 1'h0);
        // short-frame ending: a fixed wait from the empty event instead of disabling
        d = 8'($urandom);
        u_peer.load(d);
        exp_q.push_back(d);
        send(8'($urandom), 1'h0);
        wait_on(0, 1'h1);
        repeat (2 * FRAME_W * HALF_CYC + 2) @(posedge core_clk);
        `CHK(transfer_active_flag, 1'h0)
        // receive-only master runs by itself; disabling mid-frame stops it after one word
        d = 8'($urandom);
        u_peer.load(d);
        exp_q.push_back(d);
        rx_only <= 1'h1;
        wait_on(1, 1'h1);
        serial_port_enable <= 1'h0;
        wait_on(1, 1'h0);
        rx_only <= 1'h0;
        serial_port_enable <= 1'h1;
        // transmit-only bidir frame closed by disabling mid-frame
        bidir_mode <= 1'h1;
        bidir_out <= 1'h1;
        d = 8'($urandom);
        send(d, 1'h0);
        wait_on(0, 1'h1);
        serial_port_enable <= 1'h0;
        wait_on(1, 1'h1);
        wait_on(1, 1'h0);
        `CHK(u_peer.got, d)
        // slave frames clocked by the peer at 64 ns
        bidir_mode <= 1'h0;
        bidir_out <= 1'h0;
        master_mode <= 1'h0;
        serial_port_enable <= 1'h1;
        repeat (3) begin
            d = 8'($urandom);
            exp_q.push_back(d);
            u_peer.xfer(d);
            // frame end taken from the receive event, then from slave busy dropping
            wait_on(2, 1'h1);
            wait_on(1, 1'h0);
            repeat (8) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
        `CHK(exp_q.size() == 0, 1'h1)
        stop_test();
    end
endmodule : tb_top
